/* hw/mmu_check_pkg.sv */
package mmu_check_pkg;

  // Register offsets on the plain register port
  localparam logic [7:0] CTRL_OFFSET       = 8'h00;
  localparam logic [7:0] DOMAIN_CTRL_OFFSET = 8'h04;
  localparam logic [7:0] FAULT_STATUS_OFFSET = 8'h08;
  localparam logic [7:0] FAULT_ADDR_OFFSET  = 8'h0C;

  // Control register fields
  localparam int CTRL_ALIGN_EN_BIT = 0;
  localparam int CTRL_SYSTEM_BIT   = 1;
  localparam int CTRL_ROM_BIT      = 2;
  localparam int CTRL_DUAL_POL_BIT = 3;
  localparam int CTRL_WIDTH        = 4;
  localparam logic [3:0] CTRL_RESET = 4'h0;

  // Fault status register fields
  localparam int STATUS_CODE_LSB   = 0;
  localparam int STATUS_DOM_LSB    = 4;
  localparam int STATUS_DVALID_BIT = 8;
  localparam int STATUS_WIDTH      = 9;
  localparam logic [8:0]  STATUS_RESET     = 9'h000;
  localparam logic [31:0] FAULT_ADDR_RESET = 32'h0000_0000;
  localparam logic [31:0] DACR_RESET       = 32'h0000_0000;

  // Descriptor fields
  localparam int DESC_CB_LSB   = 2;
  localparam int DESC_DOM_LSB  = 5;
  localparam int SEC_AP_LSB    = 10;
  localparam int PAGE_AP_LSB   = 4;
  localparam logic [1:0] L1_SECTION  = 2'h2;
  localparam logic [1:0] L1_PAGE_TBL = 2'h1;
  localparam logic [1:0] L2_LARGE    = 2'h1;
  localparam logic [1:0] L2_SMALL    = 2'h2;

  // Domain access values
  localparam logic [1:0] DOM_NO_ACCESS = 2'h0;
  localparam logic [1:0] DOM_CLIENT    = 2'h1;
  localparam logic [1:0] DOM_RESERVED  = 2'h2;
  localparam logic [1:0] DOM_MANAGER   = 2'h3;

  // Access sizes
  localparam logic [1:0] SIZE_BYTE = 2'h0;
  localparam logic [1:0] SIZE_HALF = 2'h1;
  localparam logic [1:0] SIZE_WORD = 2'h2;

  // Fault cause codes
  localparam logic [3:0] FC_TERMINAL    = 4'h2;
  localparam logic [3:0] FC_VECTOR      = 4'h0;
  localparam logic [3:0] FC_ALIGN       = 4'h1;
  localparam logic [3:0] FC_XLAT_EXT_L1 = 4'hC;
  localparam logic [3:0] FC_XLAT_EXT_L2 = 4'hE;
  localparam logic [3:0] FC_TRANS_SEC   = 4'h5;
  localparam logic [3:0] FC_TRANS_PAGE  = 4'h7;
  localparam logic [3:0] FC_DOM_SEC     = 4'h9;
  localparam logic [3:0] FC_DOM_PAGE    = 4'hB;
  localparam logic [3:0] FC_PERM_SEC    = 4'hD;
  localparam logic [3:0] FC_PERM_PAGE   = 4'hF;
  localparam logic [3:0] FC_LINE_SEC    = 4'h4;
  localparam logic [3:0] FC_LINE_PAGE   = 4'h6;
  localparam logic [3:0] FC_NLINE_SEC   = 4'h8;
  localparam logic [3:0] FC_NLINE_PAGE  = 4'hA;

endpackage : mmu_check_pkg

/* hw/mmu_access_check.sv */
// What this block does
// - Cacheable pages may be cached and allow speculative instruction prefetch.
// - Bufferable pages may hold writes in the write buffer, unordered.
// - With both policies, attribute 10 is write-through and 11 write-back.
// - With one policy, C is cache enable and B write buffer enable.
// - Access lacking granted permission, per S and R bits, raises permission fault.
// - Sixteen domains, each a 2-bit field selected by descriptor domain number.
// - Domain value 00 means no access: every access gets a domain fault.
// - Domain value 01 is client: permission bits are also checked.
// - Domain value 11 is manager: permission bits ignored, no permission fault.
// - Aborted fetch is flagged; prefetch abort only if the instruction executes.
// - Aborted data access raises a data abort at once.
// - Memory-management aborts stop the access before any external cycle.
// - Data abort records code and domain in status, address in address register.
// - Prefetch aborts leave status and address registers unchanged.
// - Only the highest priority abort of one data access is reported.
// - Terminal 0010, vector 0000, alignment 0001.
// - External abort on table fetch: 1100 first level, 1110 second level.
// - External abort on line fetch: 0100 section, 0110 page.
// - External abort on non-line fetch: 1000 section, 1010 page.
// - Faults before a domain is loaded record an invalid domain.
// - Section domain uses first-level descriptor; page checked at second level.
module mmu_access_check (
  // Clock and reset
  input  wire logic        i_sys_clk,
  input  wire logic        i_sys_rst,
  // Register port
  input  wire logic [7:0]  i_reg_addr,
  input  wire logic [31:0] i_reg_wdata,
  input  wire logic        i_reg_wr,
  input  wire logic        i_reg_rd,
  output logic      [31:0] o_reg_rdata,
  // Access request from the core, descriptors from the walker
  input  wire logic        i_acc_valid,
  input  wire logic [31:0] i_acc_vaddr,
  input  wire logic        i_acc_fetch,
  input  wire logic        i_acc_write,
  input  wire logic [1:0]  i_acc_size,
  input  wire logic        i_acc_priv,
  input  wire logic        i_acc_linefetch,
  input  wire logic        i_acc_terminal,
  input  wire logic        i_acc_vector,
  input  wire logic [31:0] i_l1_desc,
  input  wire logic        i_l1_ext_abort,
  input  wire logic [31:0] i_l2_desc,
  input  wire logic        i_l2_ext_abort,
  // External memory side
  output logic             o_mem_start,
  output logic      [31:0] o_mem_paddr,
  output logic             o_mem_write,
  output logic             o_mem_linefetch,
  output logic             o_mem_cacheable,
  output logic             o_mem_bufferable,
  output logic             o_mem_writeback,
  output logic             o_mem_prefetch_ok,
  input  wire logic        i_mem_abort,
  // Abort signalling to the core
  output logic             o_data_abort,
  output logic             o_fetch_done,
  output logic             o_fetch_abort_flag,
  input  wire logic        i_exec_valid,
  input  wire logic        i_exec_abort_flag,
  output logic             o_prefetch_abort
);

  logic [3:0]  ctrl_q;
  logic [31:0] dacr_q;
  logic [8:0]  status_q;
  logic [31:0] fault_addr_q;

  // Access permission decode; encodings of the bits are fixed here
  function automatic logic perm_ok(input logic [1:0] ap, input logic sys, input logic rom,
                                   input logic priv, input logic wr);
    logic ok;
    ok = 1'b0;
    unique case (ap)
      2'h0: ok = !wr && ((sys && priv) || rom);
      2'h1: ok = priv;
      2'h2: ok = priv || !wr;
      2'h3: ok = 1'b1;
    endcase
    return ok;
  endfunction : perm_ok

  // Descriptor decode
  logic [1:0]  l1_type;
  logic [1:0]  l2_type;
  logic        is_section;
  logic        is_page;
  logic        l1_bad;
  logic        l2_bad;
  logic [3:0]  dom_num;
  logic [1:0]  dom_mode;
  logic [1:0]  sub_idx;
  logic [1:0]  ap_sel;
  logic [1:0]  cb_sel;
  logic        misaligned;
  logic        access_ok;
  logic [31:0] paddr;

  assign l1_type    = i_l1_desc[1:0];
  assign l2_type    = i_l2_desc[1:0];
  assign is_section = (l1_type == mmu_check_pkg::L1_SECTION);
  assign is_page    = (l1_type == mmu_check_pkg::L1_PAGE_TBL);
  assign l1_bad     = !is_section && !is_page;
  assign l2_bad     = (l2_type != mmu_check_pkg::L2_LARGE)
                   && (l2_type != mmu_check_pkg::L2_SMALL);
  assign dom_num    = i_l1_desc[mmu_check_pkg::DESC_DOM_LSB +: 4];
  assign dom_mode   = dacr_q[{dom_num, 1'b0} +: 2];
  assign sub_idx    = (l2_type == mmu_check_pkg::L2_LARGE) ? i_acc_vaddr[15:14]
                                                            : i_acc_vaddr[11:10];
  assign ap_sel     = is_section ? i_l1_desc[mmu_check_pkg::SEC_AP_LSB +: 2]
                                 : i_l2_desc[mmu_check_pkg::PAGE_AP_LSB + {sub_idx, 1'b0} +: 2];
  assign cb_sel     = is_section ? i_l1_desc[mmu_check_pkg::DESC_CB_LSB +: 2]
                                 : i_l2_desc[mmu_check_pkg::DESC_CB_LSB +: 2];
  assign access_ok  = perm_ok(ap_sel, ctrl_q[mmu_check_pkg::CTRL_SYSTEM_BIT],
                              ctrl_q[mmu_check_pkg::CTRL_ROM_BIT], i_acc_priv, i_acc_write);
  assign misaligned = ((i_acc_size == mmu_check_pkg::SIZE_WORD) && (i_acc_vaddr[1:0] != 2'h0))
                   || ((i_acc_size == mmu_check_pkg::SIZE_HALF) && i_acc_vaddr[0]);

  always_comb begin
    if (is_section) begin
      paddr = {i_l1_desc[31:20], i_acc_vaddr[19:0]};
    end else if (l2_type == mmu_check_pkg::L2_LARGE) begin
      paddr = {i_l2_desc[31:16], i_acc_vaddr[15:0]};
    end else begin
      paddr = {i_l2_desc[31:12], i_acc_vaddr[11:0]};
    end
  end

  // Prioritised fault encoder; earlier branches mask later ones
  logic       fault;
  logic [3:0] fault_code;
  logic       dom_valid;

  always_comb begin
    fault      = 1'b1;
    fault_code = mmu_check_pkg::FC_VECTOR;
    dom_valid  = 1'b0;
    if (i_acc_terminal) begin
      fault_code = mmu_check_pkg::FC_TERMINAL;
    end else if (i_acc_vector && !i_acc_fetch) begin
      fault_code = mmu_check_pkg::FC_VECTOR;
    end else if (ctrl_q[mmu_check_pkg::CTRL_ALIGN_EN_BIT] && !i_acc_fetch && misaligned) begin
      fault_code = mmu_check_pkg::FC_ALIGN;
    end else if (i_l1_ext_abort) begin
      fault_code = mmu_check_pkg::FC_XLAT_EXT_L1;
    end else if (l1_bad) begin
      fault_code = mmu_check_pkg::FC_TRANS_SEC;
    end else if (is_page && i_l2_ext_abort) begin
      fault_code = mmu_check_pkg::FC_XLAT_EXT_L2;
      dom_valid  = 1'b1;
    end else if (is_page && l2_bad) begin
      fault_code = mmu_check_pkg::FC_TRANS_PAGE;
      dom_valid  = 1'b1;
    end else if ((dom_mode == mmu_check_pkg::DOM_NO_ACCESS)
              || (dom_mode == mmu_check_pkg::DOM_RESERVED)) begin
      fault_code = is_section ? mmu_check_pkg::FC_DOM_SEC : mmu_check_pkg::FC_DOM_PAGE;
      dom_valid  = 1'b1;
    end else if ((dom_mode == mmu_check_pkg::DOM_CLIENT) && !access_ok) begin
      fault_code = is_section ? mmu_check_pkg::FC_PERM_SEC : mmu_check_pkg::FC_PERM_PAGE;
      dom_valid  = 1'b1;
    end else begin
      fault      = 1'b0;
    end
  end

  logic req_data_abort;
  logic req_fetch_abort;
  assign req_data_abort  = i_acc_valid && !i_acc_fetch && fault;
  assign req_fetch_abort = i_acc_valid && i_acc_fetch && fault;

  // Context of the access now in flight externally, for later memory aborts
  logic        ctx_data_q;
  logic        ctx_page_q;
  logic        ctx_line_q;
  logic [3:0]  ctx_dom_q;
  logic [31:0] ctx_vaddr_q;

  always_ff @(posedge i_sys_clk) begin
    if (i_sys_rst) begin
      ctx_data_q  <= 1'b0;
      ctx_page_q  <= 1'b0;
      ctx_line_q  <= 1'b0;
      ctx_dom_q   <= 4'h0;
      ctx_vaddr_q <= 32'h0000_0000;
    end else if (i_acc_valid && !fault) begin
      ctx_data_q  <= !i_acc_fetch;
      ctx_page_q  <= is_page;
      ctx_line_q  <= i_acc_linefetch;
      ctx_dom_q   <= dom_num;
      ctx_vaddr_q <= i_acc_vaddr;
    end
  end

  logic [3:0] mem_code;
  logic       mem_data_abort;
  logic       mem_fetch_abort;
  assign mem_code = ctx_line_q
                  ? (ctx_page_q ? mmu_check_pkg::FC_LINE_PAGE : mmu_check_pkg::FC_LINE_SEC)
                  : (ctx_page_q ? mmu_check_pkg::FC_NLINE_PAGE
                                : mmu_check_pkg::FC_NLINE_SEC);
  assign mem_data_abort  = i_mem_abort && ctx_data_q;
  assign mem_fetch_abort = i_mem_abort && !ctx_data_q;

  // External cycle launch with attributes
  always_ff @(posedge i_sys_clk) begin
    if (i_sys_rst) begin
      o_mem_start       <= 1'b0;
      o_mem_paddr       <= 32'h0000_0000;
      o_mem_write       <= 1'b0;
      o_mem_linefetch   <= 1'b0;
      o_mem_cacheable   <= 1'b0;
      o_mem_bufferable  <= 1'b0;
      o_mem_writeback   <= 1'b0;
      o_mem_prefetch_ok <= 1'b0;
    end else begin
      o_mem_start <= i_acc_valid && !fault;
      if (i_acc_valid && !fault) begin
        o_mem_paddr       <= paddr;
        o_mem_write       <= i_acc_write;
        o_mem_linefetch   <= i_acc_linefetch;
        o_mem_cacheable   <= cb_sel[1];
        o_mem_prefetch_ok <= cb_sel[1];
        // Dual policy: every cached page is buffered, B picks write-back
        if (ctrl_q[mmu_check_pkg::CTRL_DUAL_POL_BIT]) begin
          o_mem_bufferable <= cb_sel[1] || cb_sel[0];
          o_mem_writeback  <= cb_sel[1] && cb_sel[0];
        end else begin
          o_mem_bufferable <= cb_sel[0];
          o_mem_writeback  <= 1'b0;
        end
      end
    end
  end

  // Abort signalling to the core
  always_ff @(posedge i_sys_clk) begin
    if (i_sys_rst) begin
      o_data_abort       <= 1'b0;
      o_fetch_done       <= 1'b0;
      o_fetch_abort_flag <= 1'b0;
    end else begin
      o_data_abort       <= req_data_abort || mem_data_abort;
      o_fetch_done       <= (i_acc_valid && i_acc_fetch) || mem_fetch_abort;
      o_fetch_abort_flag <= req_fetch_abort || mem_fetch_abort;
    end
  end

  // Flag only bites once the tagged instruction actually executes
  assign o_prefetch_abort = i_exec_valid && i_exec_abort_flag;

  // Register file; hardware abort capture wins over a software write
  always_ff @(posedge i_sys_clk) begin
    if (i_sys_rst) begin
      ctrl_q <= mmu_check_pkg::CTRL_RESET;
      dacr_q <= mmu_check_pkg::DACR_RESET;
    end else if (i_reg_wr) begin
      if (i_reg_addr == mmu_check_pkg::CTRL_OFFSET) begin
        ctrl_q <= i_reg_wdata[mmu_check_pkg::CTRL_WIDTH-1:0];
      end
      if (i_reg_addr == mmu_check_pkg::DOMAIN_CTRL_OFFSET) begin
        dacr_q <= i_reg_wdata;
      end
    end
  end

  always_ff @(posedge i_sys_clk) begin
    if (i_sys_rst) begin
      status_q     <= mmu_check_pkg::STATUS_RESET;
      fault_addr_q <= mmu_check_pkg::FAULT_ADDR_RESET;
    end else if (mem_data_abort) begin
      // Memory abort belongs to the older access, so it is logged instead of a new data abort
      status_q     <= {1'b1, ctx_dom_q, mem_code};
      fault_addr_q <= ctx_vaddr_q;
    end else if (req_data_abort) begin
      status_q     <= {dom_valid, dom_valid ? dom_num : 4'h0, fault_code};
      fault_addr_q <= i_acc_vaddr;
    end else if (i_reg_wr) begin
      if (i_reg_addr == mmu_check_pkg::FAULT_STATUS_OFFSET) begin
        status_q <= i_reg_wdata[mmu_check_pkg::STATUS_WIDTH-1:0];
      end
      if (i_reg_addr == mmu_check_pkg::FAULT_ADDR_OFFSET) begin
        fault_addr_q <= i_reg_wdata;
      end
    end
  end

  always_ff @(posedge i_sys_clk) begin
    if (i_sys_rst) begin
      o_reg_rdata <= 32'h0000_0000;
    end else if (i_reg_rd) begin
      unique case (i_reg_addr)
        mmu_check_pkg::CTRL_OFFSET:         o_reg_rdata <= {28'h0000000, ctrl_q};
        mmu_check_pkg::DOMAIN_CTRL_OFFSET:  o_reg_rdata <= dacr_q;
        mmu_check_pkg::FAULT_STATUS_OFFSET: o_reg_rdata <= {23'h000000, status_q};
        mmu_check_pkg::FAULT_ADDR_OFFSET:   o_reg_rdata <= fault_addr_q;
        default:                            o_reg_rdata <= 32'h0000_0000;
      endcase
    end else begin
      o_reg_rdata <= 32'h0000_0000;
    end
  end

  // Checks
  default clocking cb_main @(posedge i_sys_clk); endclocking
  default disable iff (i_sys_rst);

  sequence s_data_fault;
    i_acc_valid && !i_acc_fetch && fault && !i_mem_abort;
  endsequence

  sequence s_fetch_req;
    i_acc_valid && i_acc_fetch && !i_mem_abort && !i_reg_wr;
  endsequence

  sequence s_client_or_manager;
    i_acc_valid && !fault;
  endsequence

  a_abort_blocks_mem: assert property (
    i_acc_valid && fault |=> !o_mem_start
  ) else $error("aborted access launched an external cycle");

  a_clean_access_runs: assert property (
    s_client_or_manager |=> o_mem_start && (o_mem_paddr == $past(paddr))
  ) else $error("clean access did not launch with its address");

  a_data_abort_now: assert property (
    s_data_fault |=> o_data_abort && (status_q[3:0] == $past(fault_code))
      && (fault_addr_q == $past(i_acc_vaddr))
  ) else $error("data abort not raised or not logged");

  a_fetch_keeps_log: assert property (
    s_fetch_req |=> $stable(status_q) && $stable(fault_addr_q) && o_fetch_done
      && (o_fetch_abort_flag == $past(fault))
  ) else $error("fetch abort touched fault log");

  a_terminal_first: assert property (
    s_data_fault ##0 i_acc_terminal |=> status_q[3:0] == mmu_check_pkg::FC_TERMINAL && !status_q[8]
  ) else $error("terminal exception not reported first");

  a_no_access_dom: assert property (
    i_acc_valid && !i_acc_terminal && !i_acc_vector && !misaligned && !i_l1_ext_abort
      && is_section && (dom_mode == mmu_check_pkg::DOM_NO_ACCESS) |-> fault
      && (fault_code == mmu_check_pkg::FC_DOM_SEC)
  ) else $error("no access domain did not fault");

  a_manager_no_perm: assert property (
    i_acc_valid && (dom_mode == mmu_check_pkg::DOM_MANAGER) |->
      (fault_code != mmu_check_pkg::FC_PERM_SEC) && (fault_code != mmu_check_pkg::FC_PERM_PAGE)
  ) else $error("manager domain raised permission fault");

  a_writeback_attr: assert property (
    s_client_or_manager ##0 ctrl_q[mmu_check_pkg::CTRL_DUAL_POL_BIT] ##0 (cb_sel == 2'h3)
      |=> o_mem_writeback && o_mem_bufferable && o_mem_cacheable
  ) else $error("write-back attribute not decoded");

  a_prefetch_exec: assert property (
    !i_exec_valid |-> !o_prefetch_abort
  ) else $error("prefetch abort without execution");

  a_mem_abort_code: assert property (
    i_mem_abort && ctx_data_q && !ctx_line_q |=> o_data_abort
      && (status_q[3:0] == ($past(ctx_page_q) ? mmu_check_pkg::FC_NLINE_PAGE
                                              : mmu_check_pkg::FC_NLINE_SEC))
  ) else $error("external data abort code wrong");

endmodule : mmu_access_check

/* verification/mem_far_model.sv */
module mem_far_model (
  // Clock and reset
  input  wire logic       i_sys_clk,
  input  wire logic       i_sys_rst,
  // Launch from the block and bench control
  input  wire logic       i_mem_start,
  input  wire logic       i_abort_req,
  input  wire logic [1:0] i_lat,
  // Abort back to the block
  output logic            o_mem_abort
);
  timeunit 1ns;
  timeprecision 1ns;

  logic [2:0] wait_q;
  logic       busy_q;

  // Aborts only a launched access that the bench asked to abort
  always_ff @(posedge i_sys_clk) begin
    o_mem_abort <= 1'b0;
    if (i_sys_rst) begin
      busy_q <= 1'b0;
      wait_q <= 3'h0;
    end else if (i_mem_start && i_abort_req) begin
      busy_q <= 1'b1;
      wait_q <= {1'b0, i_lat};
    end else if (busy_q) begin
      if (wait_q == 3'h0) begin
        o_mem_abort <= 1'b1;
        busy_q      <= 1'b0;
      end
      wait_q <= wait_q - 3'h1;
    end
  end
endmodule : mem_far_model

/* verification/test_mmu_access_check.sv */
module test_mmu_access_check;
  timeunit 1ns;
  timeprecision 1ps;

  localparam logic [7:0]  F_FETCH = 8'h80;
  localparam logic [7:0]  F_WR    = 8'h40;
  localparam logic [7:0]  F_PRIV  = 8'h20;
  localparam logic [7:0]  F_LINE  = 8'h10;
  localparam logic [7:0]  F_TERM  = 8'h08;
  localparam logic [7:0]  F_VEC   = 8'h04;
  localparam logic [7:0]  F_X1    = 8'h02;
  localparam logic [7:0]  F_X2    = 8'h01;
  localparam logic [31:0] VA      = 32'h0010_0100;
  localparam logic [31:0] VAM     = 32'h0010_0102;

  typedef struct {
    logic [31:0] l1;
    logic [31:0] l2;
    logic [7:0]  fl;
    logic [31:0] va;
    logic [3:0]  code;
    logic [4:0]  dom;
  } case_type;

  logic        i_sys_clk, i_sys_rst, i_reg_wr, i_reg_rd, i_acc_valid;
  logic [7:0]  i_reg_addr;
  logic [31:0] i_reg_wdata, o_reg_rdata, i_acc_vaddr, i_l1_desc, i_l2_desc, o_mem_paddr;
  logic        i_acc_fetch, i_acc_write, i_acc_priv, i_acc_linefetch, i_acc_terminal;
  logic        i_acc_vector, i_l1_ext_abort, i_l2_ext_abort, i_mem_abort;
  logic [1:0]  i_acc_size, lat;
  logic        o_mem_start, o_mem_write, o_mem_linefetch, o_mem_cacheable, o_mem_bufferable;
  logic        o_mem_writeback, o_mem_prefetch_ok, o_data_abort, o_fetch_done;
  logic        o_fetch_abort_flag, i_exec_valid, i_exec_abort_flag, o_prefetch_abort;
  logic        abort_req, da_s, ms_s, fd_s, ff_s;
  logic [31:0] rd_q;
  logic [3:0]  at_s;
  logic [3:0]  mc [4];
  case_type    ft [12];
  int          err_count;
  int          cmp_count;

  mmu_access_check dut (
    .i_sys_clk, .i_sys_rst, .i_reg_addr, .i_reg_wdata, .i_reg_wr, .i_reg_rd, .o_reg_rdata,
    .i_acc_valid, .i_acc_vaddr, .i_acc_fetch, .i_acc_write, .i_acc_size, .i_acc_priv,
    .i_acc_linefetch, .i_acc_terminal, .i_acc_vector, .i_l1_desc, .i_l1_ext_abort,
    .i_l2_desc, .i_l2_ext_abort, .o_mem_start, .o_mem_paddr, .o_mem_write,
    .o_mem_linefetch, .o_mem_cacheable, .o_mem_bufferable, .o_mem_writeback,
    .o_mem_prefetch_ok, .i_mem_abort, .o_data_abort, .o_fetch_done, .o_fetch_abort_flag,
    .i_exec_valid, .i_exec_abort_flag, .o_prefetch_abort
  );

  mem_far_model partner (
    .i_sys_clk, .i_sys_rst, .i_mem_start(o_mem_start), .i_abort_req(abort_req),
    .i_lat(lat), .o_mem_abort(i_mem_abort)
  );

  initial begin
    i_sys_clk = 1'b0;
    forever #10 i_sys_clk = ~i_sys_clk;
  end

  task automatic report_and_stop;
    $display("TB: comparisons %0d mismatches %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : report_and_stop

  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      err_count++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge i_sys_clk);
    i_reg_addr  <= a;
    i_reg_wdata <= d;
    i_reg_wr    <= 1'b1;
    @(posedge i_sys_clk);
    i_reg_wr    <= 1'b0;
  endtask : wr

  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge i_sys_clk);
    i_reg_addr <= a;
    i_reg_rd   <= 1'b1;
    @(posedge i_sys_clk);
    i_reg_rd   <= 1'b0;
    #1;
    d = o_reg_rdata;
  endtask : rd

  // Outputs are sampled just after the edge that answers the request
  task automatic acc(input logic [31:0] va, input logic [31:0] l1, input logic [31:0] l2,
                     input logic [1:0] sz, input logic [7:0] fl);
    @(posedge i_sys_clk);
    i_acc_valid <= 1'b1;
    i_acc_vaddr <= va;
    i_l1_desc   <= l1;
    i_l2_desc   <= l2;
    i_acc_size  <= sz;
    {i_acc_fetch, i_acc_write, i_acc_priv, i_acc_linefetch} <= fl[7:4];
    {i_acc_terminal, i_acc_vector, i_l1_ext_abort, i_l2_ext_abort} <= fl[3:0];
    @(posedge i_sys_clk);
    i_acc_valid <= 1'b0;
    #1;
    {da_s, ms_s, fd_s, ff_s} = {o_data_abort, o_mem_start, o_fetch_done, o_fetch_abort_flag};
  endtask : acc

  task automatic fault(input string what, input logic [3:0] code, input logic [4:0] dom,
                       input logic [31:0] va);
    chk({what, " abort"}, {30'h0, da_s, ms_s}, 32'h2);
    rd(mmu_check_pkg::FAULT_STATUS_OFFSET, rd_q);
    chk({what, " status"}, rd_q, {23'h0, dom, code});
    rd(mmu_check_pkg::FAULT_ADDR_OFFSET, rd_q);
    chk({what, " address"}, rd_q, va);
  endtask : fault

  function automatic logic [31:0] sec(input logic [3:0] d, input logic [1:0] ap,
                                      input logic [1:0] cb);
    return {12'hABC, 8'h00, ap, 1'h0, d, 1'h0, cb, 2'h2};
  endfunction : sec

  function automatic logic [31:0] pt(input logic [3:0] d);
    return {23'h0, d, 3'h0, 2'h1};
  endfunction : pt

  function automatic logic [31:0] pg(input logic [1:0] ap, input logic [1:0] cb);
    return {20'h12345, ap, ap, ap, ap, cb, 2'h2};
  endfunction : pg

  initial begin
    #200000;
    err_count++;
    report_and_stop();
  end

  initial begin
    {i_reg_addr, i_reg_wdata, i_reg_wr, i_reg_rd, i_acc_valid, i_acc_vaddr} = '0;
    {i_acc_fetch, i_acc_write, i_acc_size, i_acc_priv, i_acc_linefetch} = '0;
    {i_acc_terminal, i_acc_vector, i_l1_desc, i_l1_ext_abort, i_l2_desc} = '0;
    {i_l2_ext_abort, i_exec_valid, i_exec_abort_flag, abort_req, lat} = '0;
    i_sys_rst = 1'b1;
    repeat (16) @(posedge i_sys_clk);
    i_sys_rst <= 1'b0;
    // Four registers and one unmapped place all read zero
    for (int a = 0; a < 5; a++) begin
      rd(8'(4 * a), rd_q);
      chk("reset value", rd_q, 32'h0);
    end
    wr(8'h10, 32'hFFFF_FFFF);
    rd(8'h10, rd_q);
    chk("unmapped", rd_q, 32'h0);
    // Domains 3 and 9 none, 5 client, 7 manager; reserved value never set
    wr(mmu_check_pkg::DOMAIN_CTRL_OFFSET, 32'h0000_C400);
    rd(mmu_check_pkg::DOMAIN_CTRL_OFFSET, rd_q);
    chk("domain control", rd_q, 32'h0000_C400);
    wr(mmu_check_pkg::CTRL_OFFSET, 32'h0000_0001);
    ft[0]  = '{sec(4'h3, 2'h1, 2'h0), 32'h0, F_PRIV, VA, mmu_check_pkg::FC_DOM_SEC, 5'h13};
    ft[1]  = '{sec(4'h9, 2'h1, 2'h0), 32'h0, F_PRIV, VA, mmu_check_pkg::FC_DOM_SEC, 5'h19};
    ft[2]  = '{sec(4'h5, 2'h1, 2'h0), 32'h0, 8'h00, VA, mmu_check_pkg::FC_PERM_SEC, 5'h15};
    ft[3]  = '{pt(4'h3), pg(2'h1, 2'h0), F_PRIV, VA, mmu_check_pkg::FC_DOM_PAGE, 5'h13};
    ft[4]  = '{pt(4'h5), pg(2'h1, 2'h0), 8'h00, VA, mmu_check_pkg::FC_PERM_PAGE, 5'h15};
    ft[5]  = '{32'h0, 32'h0, F_PRIV, VA, mmu_check_pkg::FC_TRANS_SEC, 5'h00};
    ft[6]  = '{pt(4'h5), 32'h0, F_PRIV, VA, mmu_check_pkg::FC_TRANS_PAGE, 5'h15};
    ft[7]  = '{sec(4'h3, 2'h1, 2'h0), 32'h0, F_PRIV | F_X1, VA, mmu_check_pkg::FC_XLAT_EXT_L1,
               5'h00};
    ft[8]  = '{pt(4'h3), pg(2'h1, 2'h0), F_PRIV | F_X2, VA, mmu_check_pkg::FC_XLAT_EXT_L2,
               5'h13};
    ft[9]  = '{sec(4'h3, 2'h1, 2'h0), 32'h0, F_PRIV | F_X1 | F_TERM | F_VEC, VAM,
               mmu_check_pkg::FC_TERMINAL, 5'h00};
    ft[10] = '{sec(4'h3, 2'h1, 2'h0), 32'h0, F_PRIV | F_X1 | F_VEC, VAM,
               mmu_check_pkg::FC_VECTOR, 5'h00};
    ft[11] = '{sec(4'h3, 2'h1, 2'h0), 32'h0, F_PRIV | F_X1, VAM, mmu_check_pkg::FC_ALIGN, 5'h00};
    for (int i = 0; i < 12; i++) begin
      acc(ft[i].va, ft[i].l1, ft[i].l2, mmu_check_pkg::SIZE_WORD, ft[i].fl);
      fault($sformatf("case %0d", i), ft[i].code, ft[i].dom, ft[i].va);
    end
    // User access to a privileged-only section passes only as manager
    for (int p = 0; p < 2; p++) begin
      wr(mmu_check_pkg::CTRL_OFFSET, {28'h0, p[0], 3'h1});
      for (int c = 0; c < 4; c++) begin
        acc(VA, sec(4'h7, 2'h1, c[1:0]), 32'h0, mmu_check_pkg::SIZE_WORD, 8'h00);
        chk("manager launch", {30'h0, da_s, ms_s}, 32'h1);
        chk("paddr", o_mem_paddr, {12'hABC, VA[19:0]});
        at_s = {c[1], c[1], p[0] ? (c[1] | c[0]) : c[0], p[0] & c[1] & c[0]};
        chk("attributes", 32'({o_mem_cacheable, o_mem_prefetch_ok,
            o_mem_bufferable, o_mem_writeback}), {28'h0, at_s});
      end
    end
    mc = '{mmu_check_pkg::FC_NLINE_SEC, mmu_check_pkg::FC_NLINE_PAGE,
           mmu_check_pkg::FC_LINE_SEC, mmu_check_pkg::FC_LINE_PAGE};
    // Far side answers with a growing delay
    for (int m = 0; m < 4; m++) begin
      abort_req <= 1'b1;
      lat       <= m[1:0];
      acc(VA, m[0] ? pt(4'h7) : sec(4'h7, 2'h1, 2'h0), pg(2'h1, 2'h0),
          mmu_check_pkg::SIZE_WORD, F_PRIV | (m[1] ? F_LINE : F_WR));
      chk("launch", {31'h0, ms_s}, 32'h1);
      chk("write and line", {30'h0, o_mem_write, o_mem_linefetch}, {30'h0, !m[1], m[1]});
      for (int n = 0; n < 10 && o_data_abort !== 1'b1; n++) begin
        @(posedge i_sys_clk);
        #1;
      end
      abort_req <= 1'b0;
      {da_s, ms_s} = {o_data_abort, o_mem_start};
      fault($sformatf("memory %0d", m), mc[m], 5'h17, VA);
    end
    acc(32'h0020_0200, sec(4'h3, 2'h1, 2'h0), 32'h0, mmu_check_pkg::SIZE_WORD, F_FETCH);
    chk("fetch abort", {28'h0, da_s, ms_s, fd_s, ff_s}, 32'h3);
    rd(mmu_check_pkg::FAULT_STATUS_OFFSET, rd_q);
    chk("status kept", rd_q, {23'h0, 5'h17, mmu_check_pkg::FC_LINE_PAGE});
    rd(mmu_check_pkg::FAULT_ADDR_OFFSET, rd_q);
    chk("address kept", rd_q, VA);
    // Far side then aborts the clean fetch: flagged only, log untouched
    {abort_req, lat} <= 3'h4;
    acc(32'h0020_0200, sec(4'h7, 2'h1, 2'h0), 32'h0, mmu_check_pkg::SIZE_WORD, F_FETCH);
    chk("fetch clean", {28'h0, da_s, ms_s, fd_s, ff_s}, 32'h6);
    repeat (3) @(posedge i_sys_clk);
    #1;
    abort_req <= 1'b0;
    chk("ext fetch", {29'h0, o_data_abort, o_fetch_done, o_fetch_abort_flag}, 32'h3);
    rd(mmu_check_pkg::FAULT_STATUS_OFFSET, rd_q);
    chk("status still kept", rd_q, {23'h0, 5'h17, mmu_check_pkg::FC_LINE_PAGE});
    for (int k = 0; k < 4; k++) begin
      @(posedge i_sys_clk);
      {i_exec_valid, i_exec_abort_flag} <= k[1:0];
      #1;
      chk("prefetch abort", {31'h0, o_prefetch_abort}, {31'h0, k == 3});
    end
    report_and_stop();
  end
endmodule : test_mmu_access_check
